// File: logic/srcl_top.sv
// Purpose: speed reference zero clamp, limits and speed status outputs
// Assumes: speeds in RPM as signed codes, position in encoder pulses
// Notes: all registers take effect on the cycle after the write
`timescale 1ns/1ns
`include "srcl_cfg.svh"
module srcl_top (
	// Clock and reset
	input logic clock,
	input logic arst_n,
	// Register bus
	input srcl_pkg::srcl_axi_req_t axi_req,
	output srcl_pkg::srcl_axi_rsp_t axi_rsp,
	// Clamp pin and drive state
	input logic hold_at_zero_input,
	input logic drive_running,
	input logic speed_mode,
	input logic [15:0] motor_max_speed,
	// Reference and feedback
	input logic signed [15:0] speed_ref,
	input logic signed [15:0] speed_fb,
	input logic signed [31:0] pos_fb,
	// Conditioned reference
	output logic signed [15:0] speed_cmd,
	output logic clamp_active,
	// Status
	output logic motor_rotating_flag,
	output logic speed_match_flag,
	output logic overspeed_fault,
	output logic [3:0] do_pins,
	output logic irq
);
	import srcl_pkg::*;
	srcl_state_t st_ff;
	srcl_state_t nxt_st;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_ok;
	logic [7:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_ok;
	logic signed [15:0] speed_filt;
	logic [17:0] eff_fwd;
	logic [17:0] eff_rev;
	logic clamp_cond;
	logic signed [31:0] hold_err;
	logic hold_small;
	logic signed [15:0] lim_ref;
	logic [3:0] do_val;
	logic [2:0] ev;
	srcl_regs_t rg;

	// Magnitude of a sign-extended speed
	function automatic logic [17:0] mag(input logic signed [17:0] v);
		mag = v[17] ? 18'(-v) : 18'(v);
	endfunction

	// Saturate a value to the given forward and reverse magnitudes
	function automatic logic signed [15:0] sat(input logic signed [47:0] v,
			input logic [17:0] fwd, input logic [17:0] rev);
		logic signed [47:0] hi;
		logic signed [47:0] lo;
		hi = $signed({30'h0000_0000, fwd});
		lo = -$signed({30'h0000_0000, rev});
		if (v > hi) begin
			sat = 16'(hi);
		end else if (v < lo) begin
			sat = 16'(lo);
		end else begin
			sat = 16'(v);
		end
	endfunction

	// Merge the written byte lanes into a 16-bit setting
	function automatic logic [15:0] wm(input logic [15:0] old,
			input logic [31:0] d, input logic [3:0] b);
		wm = {b[1] ? d[15:8] : old[15:8], b[0] ? d[7:0] : old[7:0]};
	endfunction

	// Smaller of two magnitudes
	function automatic logic [17:0] min2(input logic [17:0] a,
			input logic [17:0] b);
		min2 = (a < b) ? a : b;
	endfunction

	// Bus front end
	srcl_axil srcl_axil_i (
		.clock(clock),
		.arst_n(arst_n),
		.req(axi_req),
		.rsp(axi_rsp),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_ok(wr_ok),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_ok(rd_ok)
	);

	// Speed feedback filter for the rotation and match comparators
	srcl_filt srcl_filt_i (
		.clock(clock),
		.arst_n(arst_n),
		.x(speed_fb),
		.shift(st_ff.regs.filt_shift),
		.y(speed_filt)
	);

	// Effective limits and clamp condition from live settings
	always_comb begin
		rg = st_ff.regs;
		eff_fwd = min2(min2({2'h0, motor_max_speed}, {2'h0, rg.max_lim}),
			min2({2'h0, rg.fwd_lim}, `SRCL_SPEED_CAP));
		eff_rev = min2(min2({2'h0, motor_max_speed}, {2'h0, rg.max_lim}),
			min2({2'h0, rg.rev_lim}, `SRCL_SPEED_CAP));
		clamp_cond = speed_mode && st_ff.hold_in &&
			(mag(18'(speed_ref)) <= {2'h0, rg.clamp_thr});
		hold_err = st_ff.hold_pos - pos_fb;
		hold_small = (hold_err <= $signed(`SRCL_HOLD_BAND)) &&
			(hold_err >= -$signed(`SRCL_HOLD_BAND));
		lim_ref = sat(48'(speed_ref), eff_fwd, eff_rev);
	end

	// Read decode
	always_comb begin
		rd_ok = 1'h1;
		rd_data = 32'h0000_0000;
		if (rd_addr == `SRCL_OFS_CLAMP_THR) begin
			rd_data[15:0] = st_ff.regs.clamp_thr;
		end else if (rd_addr == `SRCL_OFS_MAX_LIM) begin
			rd_data[15:0] = st_ff.regs.max_lim;
		end else if (rd_addr == `SRCL_OFS_FWD_LIM) begin
			rd_data[15:0] = st_ff.regs.fwd_lim;
		end else if (rd_addr == `SRCL_OFS_REV_LIM) begin
			rd_data[15:0] = st_ff.regs.rev_lim;
		end else if (rd_addr == `SRCL_OFS_ROT_THR) begin
			rd_data[15:0] = st_ff.regs.rot_thr;
		end else if (rd_addr == `SRCL_OFS_MATCH_THR) begin
			rd_data[15:0] = st_ff.regs.match_thr;
		end else if (rd_addr == `SRCL_OFS_OVS_THR) begin
			rd_data[15:0] = st_ff.regs.ovs_thr;
		end else if (rd_addr == `SRCL_OFS_FILT) begin
			rd_data[3:0] = st_ff.regs.filt_shift;
		end else if (rd_addr == `SRCL_OFS_DO_CFG) begin
			rd_data[11:0] = {st_ff.regs.do_pol, st_ff.regs.do_sel};
		end else if (rd_addr == `SRCL_OFS_POS_GAIN) begin
			rd_data[3:0] = st_ff.regs.pos_shift;
		end else if (rd_addr == `SRCL_OFS_STATUS) begin
			rd_data[4:0] = {st_ff.hold_in, st_ff.clamp, st_ff.match,
				st_ff.rot, st_ff.ovs};
		end else if (rd_addr == `SRCL_OFS_IRQ_STAT) begin
			rd_data[2:0] = st_ff.irq_stat;
		end else if (rd_addr == `SRCL_OFS_IRQ_MASK) begin
			rd_data[2:0] = st_ff.regs.irq_mask;
		end else begin
			rd_ok = 1'h0;
		end
	end

	// Route the chosen flag to each pin with its own polarity
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_do
			logic f;
			assign f = (st_ff.regs.do_sel[gi] == SRCL_DO_ROT) ? st_ff.rot :
				(st_ff.regs.do_sel[gi] == SRCL_DO_MATCH) ? st_ff.match :
				(st_ff.regs.do_sel[gi] == SRCL_DO_CLAMP) ? st_ff.clamp :
				1'h0;
			assign do_val[gi] = st_ff.regs.do_pol[gi] ? f : !f;
		end
	endgenerate

	// Next state: registers, clamp machine, comparators, interrupts
	always_comb begin
		nxt_st = st_ff;
		wr_ok = 1'h1;
		// Register writes
		if (wr_en) begin
			if (wr_addr == `SRCL_OFS_CLAMP_THR) begin
				nxt_st.regs.clamp_thr = wm(rg.clamp_thr, wr_data, wr_strb);
			end else if (wr_addr == `SRCL_OFS_MAX_LIM) begin
				nxt_st.regs.max_lim = wm(rg.max_lim, wr_data, wr_strb);
			end else if (wr_addr == `SRCL_OFS_FWD_LIM) begin
				nxt_st.regs.fwd_lim = wm(rg.fwd_lim, wr_data, wr_strb);
			end else if (wr_addr == `SRCL_OFS_REV_LIM) begin
				nxt_st.regs.rev_lim = wm(rg.rev_lim, wr_data, wr_strb);
			end else if (wr_addr == `SRCL_OFS_ROT_THR) begin
				nxt_st.regs.rot_thr = wm(rg.rot_thr, wr_data, wr_strb);
			end else if (wr_addr == `SRCL_OFS_MATCH_THR) begin
				nxt_st.regs.match_thr = wm(rg.match_thr, wr_data, wr_strb);
			end else if (wr_addr == `SRCL_OFS_OVS_THR) begin
				nxt_st.regs.ovs_thr = wm(rg.ovs_thr, wr_data, wr_strb);
			end else if (wr_addr == `SRCL_OFS_FILT) begin
				if (wr_strb[0]) nxt_st.regs.filt_shift = wr_data[3:0];
			end else if (wr_addr == `SRCL_OFS_DO_CFG) begin
				if (wr_strb[0]) begin
					for (int i = 0; i < 4; i++) begin
						nxt_st.regs.do_sel[i] = srcl_do_fn_t'(wr_data[2*i+:2]);
					end
				end
				if (wr_strb[1]) nxt_st.regs.do_pol = wr_data[11:8];
			end else if (wr_addr == `SRCL_OFS_POS_GAIN) begin
				if (wr_strb[0]) nxt_st.regs.pos_shift = wr_data[3:0];
			end else if (wr_addr == `SRCL_OFS_IRQ_MASK) begin
				if (wr_strb[0]) nxt_st.regs.irq_mask = wr_data[2:0];
			end else if (wr_addr != `SRCL_OFS_IRQ_STAT &&
					wr_addr != `SRCL_OFS_STATUS) begin
				wr_ok = 1'h0;
			end
		end
		// Pin synchroniser: accept a change once stages two and three agree
		nxt_st.sync = {st_ff.sync[1:0], hold_at_zero_input};
		if (st_ff.sync[1] == st_ff.sync[2]) begin
			nxt_st.hold_in = st_ff.sync[2];
		end
		// Clamp machine
		case (st_ff.clamp)
			SRCL_FREE: begin
				nxt_st.speed_cmd = lim_ref;
				if (clamp_cond) begin
					nxt_st.clamp = SRCL_HOLD;
					nxt_st.hold_pos = pos_fb;
					nxt_st.speed_cmd = 16'h0000;
				end
			end
			SRCL_HOLD: begin
				if (!clamp_cond) begin
					nxt_st.clamp = SRCL_FREE;
					nxt_st.speed_cmd = lim_ref;
				end else if (hold_small) begin
					nxt_st.speed_cmd = 16'h0000;
				end else begin
					nxt_st.speed_cmd = sat(48'(hold_err) <<< rg.pos_shift,
						eff_fwd, eff_rev);
				end
			end
			default: begin
				nxt_st.clamp = SRCL_FREE;
			end
		endcase
		// Comparators
		nxt_st.ovs = mag(18'(speed_fb)) > {2'h0, rg.ovs_thr};
		nxt_st.rot = mag(18'(speed_filt)) >= {2'h0, rg.rot_thr};
		nxt_st.match = drive_running && speed_mode &&
			(mag(18'(speed_filt) - 18'(lim_ref)) <=
			{2'h0, rg.match_thr});
		nxt_st.do_pins = do_val;
		// Sticky events; a new event wins over a clearing write
		ev = {nxt_st.rot && !st_ff.rot,
			nxt_st.clamp == SRCL_HOLD && st_ff.clamp == SRCL_FREE,
			nxt_st.ovs && !st_ff.ovs};
		if (wr_en && wr_addr == `SRCL_OFS_IRQ_STAT && wr_strb[0]) begin
			nxt_st.irq_stat = st_ff.irq_stat & ~wr_data[2:0];
		end
		nxt_st.irq_stat = nxt_st.irq_stat | ev;
		nxt_st.irq = |(nxt_st.irq_stat & nxt_st.regs.irq_mask);
	end

	// State register
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			st_ff <= '0;
			st_ff.regs.clamp_thr <= `SRCL_RST_CLAMP_THR;
			st_ff.regs.max_lim <= `SRCL_RST_LIMIT;
			st_ff.regs.fwd_lim <= `SRCL_RST_LIMIT;
			st_ff.regs.rev_lim <= `SRCL_RST_LIMIT;
			st_ff.regs.rot_thr <= `SRCL_RST_ROT_THR;
			st_ff.regs.match_thr <= `SRCL_RST_MATCH_THR;
			st_ff.regs.ovs_thr <= `SRCL_RST_OVS_THR;
			st_ff.regs.filt_shift <= `SRCL_RST_FILT;
			st_ff.regs.pos_shift <= `SRCL_RST_POS_GAIN;
			st_ff.do_pins <= 4'hf;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from the state flops
	assign speed_cmd = st_ff.speed_cmd;
	assign clamp_active = st_ff.clamp;
	assign motor_rotating_flag = st_ff.rot;
	assign speed_match_flag = st_ff.match;
	assign overspeed_fault = st_ff.ovs;
	assign do_pins = st_ff.do_pins;
	assign irq = st_ff.irq;

	// Checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);

	property p_enter;
		clamp_cond && st_ff.clamp == SRCL_FREE |=>
			clamp_active && st_ff.hold_pos == $past(pos_fb) && speed_cmd == 0;
	endproperty
	a_enter: assert property (p_enter) else $error("clamp entry");
	property p_band;
		clamp_cond && st_ff.clamp == SRCL_HOLD && hold_small |=> speed_cmd == 0;
	endproperty
	a_band: assert property (p_band) else $error("hold band");
	property p_leave;
		speed_mode && mag(18'(speed_ref)) > {2'h0, rg.clamp_thr} |=> !clamp_active;
	endproperty
	a_leave: assert property (p_leave) else $error("clamp exit");
	property p_pin_off;
		!st_ff.hold_in |=> !clamp_active;
	endproperty
	a_pin_off: assert property (p_pin_off) else $error("pin off");
	property p_ovs;
		mag(18'(speed_fb)) > {2'h0, rg.ovs_thr} |=> overspeed_fault;
	endproperty
	a_ovs: assert property (p_ovs) else $error("overspeed");
	// The sticky bit is set on the same edge as the fault rises
	property p_ovs_stk;
		$rose(overspeed_fault) |-> st_ff.irq_stat[0];
	endproperty
	a_ovs_stk: assert property (p_ovs_stk) else $error("sticky");
	property p_fwd;
		!clamp_cond && st_ff.clamp == SRCL_FREE |=>
			$signed(18'(speed_cmd)) <= $signed(18'($past(eff_fwd))) &&
			-$signed(18'(speed_cmd)) <= $signed(18'($past(eff_rev)));
	endproperty
	a_fwd: assert property (p_fwd) else $error("limit");
	property p_eff;
		eff_fwd <= {2'h0, rg.max_lim} && eff_fwd <= {2'h0, rg.fwd_lim} &&
			eff_rev <= {2'h0, rg.rev_lim} && eff_rev <= {2'h0, motor_max_speed};
	endproperty
	a_eff: assert property (p_eff) else $error("effective limit");
	property p_rot;
		mag(18'(speed_filt)) >= {2'h0, rg.rot_thr} |=> motor_rotating_flag;
	endproperty
	a_rot: assert property (p_rot) else $error("rotation flag");
	property p_match_off;
		!(drive_running && speed_mode) |=> !speed_match_flag;
	endproperty
	a_match_off: assert property (p_match_off) else $error("match");
	property p_pin;
		st_ff.regs.do_sel[0] == SRCL_DO_NONE |=>
			do_pins[0] == !$past(st_ff.regs.do_pol[0]);
	endproperty
	a_pin: assert property (p_pin) else $error("do pin");
	c_clamp: cover property (clamp_cond ##1 clamp_active ##[1:20] !clamp_active);
	c_match: cover property (speed_match_flag && motor_rotating_flag);
	c_irq: cover property ($rose(irq));
endmodule

// File: logic/srcl_cfg.svh
// Purpose: offsets, reset values and fixed codes of the speed clamp block
// Assumes: byte addresses on an 8-bit AXI4-Lite window, one word each
// Notes: included by the top module, the bus front end and the bench
`ifndef SRCL_CFG_SVH
`define SRCL_CFG_SVH
// Register byte offsets
`define SRCL_OFS_CLAMP_THR 8'h00
`define SRCL_OFS_MAX_LIM 8'h04
`define SRCL_OFS_FWD_LIM 8'h08
`define SRCL_OFS_REV_LIM 8'h0c
`define SRCL_OFS_ROT_THR 8'h10
`define SRCL_OFS_MATCH_THR 8'h14
`define SRCL_OFS_OVS_THR 8'h18
`define SRCL_OFS_FILT 8'h1c
`define SRCL_OFS_DO_CFG 8'h20
`define SRCL_OFS_POS_GAIN 8'h24
`define SRCL_OFS_STATUS 8'h28
`define SRCL_OFS_IRQ_STAT 8'h2c
`define SRCL_OFS_IRQ_MASK 8'h30
// Reset values
`define SRCL_RST_CLAMP_THR 16'h000a
`define SRCL_RST_LIMIT 16'h1770
`define SRCL_RST_ROT_THR 16'h0014
`define SRCL_RST_MATCH_THR 16'h000a
`define SRCL_RST_OVS_THR 16'h1900
`define SRCL_RST_FILT 4'h2
`define SRCL_RST_POS_GAIN 4'h0
// Field positions in DO_CFG: selects in [7:0], polarity in [11:8]
`define SRCL_DO_POL_LSB 8
// Largest positive speed code and position deadband in pulses
`define SRCL_SPEED_CAP 18'h0_7fff
`define SRCL_HOLD_BAND 32'h0000_0001
// Bus answers
`define SRCL_RESP_OKAY 2'h0
`define SRCL_RESP_SLVERR 2'h2
`endif

// File: logic/srcl_pkg.sv
// Purpose: types shared by the speed clamp block
// Assumes: constants live in srcl_cfg.svh
// Notes: top and bus front end state is carried as packed structs
package srcl_pkg;
	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} srcl_axi_req_t;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} srcl_axi_rsp_t;
	typedef enum logic [1:0] {
		SRCL_DO_NONE = 2'b00,
		SRCL_DO_ROT = 2'b01,
		SRCL_DO_MATCH = 2'b10,
		SRCL_DO_CLAMP = 2'b11
	} srcl_do_fn_t;
	typedef enum logic {
		SRCL_FREE = 1'b0,
		SRCL_HOLD = 1'b1
	} srcl_clamp_t;
	typedef struct packed {
		logic [15:0] clamp_thr;
		logic [15:0] max_lim;
		logic [15:0] fwd_lim;
		logic [15:0] rev_lim;
		logic [15:0] rot_thr;
		logic [15:0] match_thr;
		logic [15:0] ovs_thr;
		logic [3:0] filt_shift;
		logic [3:0] pos_shift;
		srcl_do_fn_t [3:0] do_sel;
		logic [3:0] do_pol;
		logic [2:0] irq_mask;
	} srcl_regs_t;
	typedef struct packed {
		srcl_regs_t regs;
		logic [2:0] sync;
		logic hold_in;
		srcl_clamp_t clamp;
		logic [31:0] hold_pos;
		logic [15:0] speed_cmd;
		logic rot;
		logic match;
		logic ovs;
		logic [2:0] irq_stat;
		logic [3:0] do_pins;
		logic irq;
	} srcl_state_t;
	typedef struct packed {
		logic aw_rdy;
		logic w_rdy;
		logic ar_rdy;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} srcl_axil_st_t;
endpackage

// File: logic/srcl_filt.sv
// Purpose: first-order low-pass filter of the speed feedback
// Assumes: shift sets the time constant as 2**shift clock cycles
// Notes: shift 0 passes the input through with one cycle delay
`timescale 1ns/1ns
module srcl_filt (
	// Clock and reset
	input logic clock,
	input logic arst_n,
	// Sample in, filtered value out
	input logic signed [15:0] x,
	input logic [3:0] shift,
	output logic signed [15:0] y
);
	import srcl_pkg::*;
	logic signed [31:0] acc_ff;
	logic signed [31:0] nxt_acc;
	logic signed [32:0] step;

	// Move the accumulator a fraction of the way toward the input
	always_comb begin
		step = ($signed({x[15], x, 16'h0000}) - 33'(acc_ff)) >>> shift;
		nxt_acc = acc_ff + 32'(step);
	end

	// Accumulator register
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			acc_ff <= 32'h0000_0000;
		end else begin
			acc_ff <= nxt_acc;
		end
	end

	assign y = acc_ff[31:16];
endmodule

// File: logic/srcl_axil.sv
// Purpose: AXI4-Lite slave front end for the speed clamp registers
// Assumes: one write and one read in flight at a time
// Notes: write strobe wr_en lasts one cycle; read data sampled at ar
`timescale 1ns/1ns
`include "srcl_cfg.svh"
module srcl_axil (
	// Clock and reset
	input logic clock,
	input logic arst_n,
	// Bus side
	input srcl_pkg::srcl_axi_req_t req,
	output srcl_pkg::srcl_axi_rsp_t rsp,
	// Register file side
	output logic wr_en,
	output logic [7:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input logic wr_ok,
	output logic [7:0] rd_addr,
	input logic [31:0] rd_data,
	input logic rd_ok
);
	import srcl_pkg::*;
	srcl_axil_st_t s_ff;
	srcl_axil_st_t nxt_s;

	// Write lanes may arrive in either order; read answers next cycle
	always_comb begin
		nxt_s = s_ff;
		wr_en = s_ff.aw_got && s_ff.w_got && !s_ff.bvalid;
		if (req.awvalid && s_ff.aw_rdy) begin
			nxt_s.aw_got = 1'h1;
			nxt_s.aw_rdy = 1'h0;
			nxt_s.awaddr = {req.awaddr[7:2], 2'h0};
		end
		if (req.wvalid && s_ff.w_rdy) begin
			nxt_s.w_got = 1'h1;
			nxt_s.w_rdy = 1'h0;
			nxt_s.wdata = req.wdata;
			nxt_s.wstrb = req.wstrb;
		end
		if (wr_en) begin
			nxt_s.bvalid = 1'h1;
			nxt_s.bresp = wr_ok ? `SRCL_RESP_OKAY : `SRCL_RESP_SLVERR;
			nxt_s.aw_got = 1'h0;
			nxt_s.w_got = 1'h0;
		end
		if (s_ff.bvalid && req.bready) begin
			nxt_s.bvalid = 1'h0;
			nxt_s.aw_rdy = 1'h1;
			nxt_s.w_rdy = 1'h1;
		end
		if (req.arvalid && s_ff.ar_rdy) begin
			nxt_s.ar_rdy = 1'h0;
			nxt_s.rvalid = 1'h1;
			nxt_s.rdata = rd_ok ? rd_data : 32'h0000_0000;
			nxt_s.rresp = rd_ok ? `SRCL_RESP_OKAY : `SRCL_RESP_SLVERR;
		end
		if (s_ff.rvalid && req.rready) begin
			nxt_s.rvalid = 1'h0;
			nxt_s.ar_rdy = 1'h1;
		end
	end

	// State register
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			s_ff <= '0;
			s_ff.aw_rdy <= 1'h1;
			s_ff.w_rdy <= 1'h1;
			s_ff.ar_rdy <= 1'h1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Answers come straight from the state flops
	assign rsp.awready = s_ff.aw_rdy;
	assign rsp.wready = s_ff.w_rdy;
	assign rsp.bvalid = s_ff.bvalid;
	assign rsp.bresp = s_ff.bresp;
	assign rsp.arready = s_ff.ar_rdy;
	assign rsp.rvalid = s_ff.rvalid;
	assign rsp.rdata = s_ff.rdata;
	assign rsp.rresp = s_ff.rresp;
	assign wr_addr = s_ff.awaddr;
	assign wr_data = s_ff.wdata;
	assign wr_strb = s_ff.wstrb;
	assign rd_addr = {req.araddr[7:2], 2'h0};
endmodule

// File: verification/srcl_plant.sv
// Purpose: load model that turns speed commands into encoder position
// Assumes: the shaft moves one pulse per cycle in the sign of the command
// Notes: load adds a push that the position hold must undo
`timescale 1ns/1ns
module srcl_plant (
	// Clock and reset
	input logic clock,
	input logic arst_n,
	// Command and disturbance in, position out
	input logic signed [15:0] speed_cmd,
	input logic signed [15:0] load,
	output logic signed [31:0] pos_ff
);
	// Integrate command sign plus any external push
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pos_ff <= 32'sh0000_0100;
		end else begin
			pos_ff <= pos_ff + 32'(load) + (speed_cmd > 0 ? 32'sd1 : 32'sd0)
				- (speed_cmd < 0 ? 32'sd1 : 32'sd0);
		end
	end
endmodule

// File: verification/srcl_top_tb.sv
// Purpose: self-checking bench for the speed clamp and status block
// Assumes: register offsets and reset codes from srcl_cfg.svh
// Notes: outputs are read just after an edge, before it updates them
`timescale 1ns/1ns
`include "srcl_cfg.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
	fail_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", \
	$time, (g), (e)); end end
module srcl_top_tb;
	import srcl_pkg::*;
	logic clock, arst_n, hold, run, smode, clamp, rot, match, ovs, irq;
	srcl_axi_req_t req;
	srcl_axi_rsp_t rsp;
	logic [15:0] mmax;
	logic signed [15:0] sref, fb, load, cmd;
	logic signed [31:0] pos, p0;
	logic [3:0] pins;
	logic [7:0] ra [6];
	logic [15:0] rv [6];
	int fail_count, n_compared, cyc;
	srcl_top srcl_top_i (.clock(clock), .arst_n(arst_n), .axi_req(req),
		.axi_rsp(rsp), .hold_at_zero_input(hold), .drive_running(run),
		.speed_mode(smode), .motor_max_speed(mmax), .speed_ref(sref),
		.speed_fb(fb), .pos_fb(pos), .speed_cmd(cmd), .clamp_active(clamp),
		.motor_rotating_flag(rot), .speed_match_flag(match),
		.overspeed_fault(ovs), .do_pins(pins), .irq(irq));
	srcl_plant srcl_plant_i (.clock(clock), .arst_n(arst_n),
		.speed_cmd(cmd), .load(load), .pos_ff(pos));
	// Clock and hang guard
	always #4 clock = ~clock;
	always @(posedge clock) begin
		cyc++;
		if (cyc == 6000) begin
			fail_count++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// One AXI4-Lite transfer, entered just after a rising edge
	task automatic axi(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic [1:0] r);
		logic ta, tw, done;
		ta = 0;
		tw = !wr;
		done = 0;
		req.awvalid <= wr;
		req.wvalid <= wr;
		req.awaddr <= a;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.bready <= wr;
		req.arvalid <= !wr;
		req.araddr <= a;
		req.rready <= !wr;
		while (!done) begin
			@(posedge clock);
			if (!ta && (wr ? rsp.awready : rsp.arready)) begin
				ta = 1;
				req.awvalid <= 0;
				req.arvalid <= 0;
			end
			if (!tw && rsp.wready) begin
				tw = 1;
				req.wvalid <= 0;
			end
			if (ta && tw && (wr ? rsp.bvalid : rsp.rvalid)) begin
				done = 1;
				q = rsp.rdata;
				r = wr ? rsp.bresp : rsp.rresp;
			end
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic [31:0] q;
		logic [1:0] r;
		axi(1, a, d, q, r);
		`CHK(r, er)
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		logic [31:0] q;
		logic [1:0] r;
		axi(0, a, 32'h0000_0000, q, r);
		`CHK(q, e)
		`CHK(r, er)
	endtask
	// Main sequence
	initial begin
		clock = 0;
		arst_n = 0;
		req = '0;
		{hold, run, smode} = 3'h0;
		mmax = 16'h1770;
		{sref, fb, load} = 48'h0000_0000_0000;
		ra = '{`SRCL_OFS_CLAMP_THR, `SRCL_OFS_MAX_LIM, `SRCL_OFS_FWD_LIM,
			`SRCL_OFS_REV_LIM, `SRCL_OFS_ROT_THR, `SRCL_OFS_MATCH_THR};
		rv = '{16'h000a, 16'h1770, 16'h1770, 16'h1770, 16'h0014, 16'h000a};
		repeat (4) @(posedge clock);
		arst_n <= 1;
		@(posedge clock);
		for (int i = 0; i < 6; i++) begin
			rd(ra[i], {16'h0000, rv[i]}, `SRCL_RESP_OKAY);
		end
		rd(8'h3c, 32'h0000_0000, `SRCL_RESP_SLVERR);
		wr(8'h3c, 32'h0000_0001, `SRCL_RESP_SLVERR);
		// Slow filter: a step must not flag rotation at once
		wr(`SRCL_OFS_FILT, 32'h0000_0004, `SRCL_RESP_OKAY);
		fb <= 16'h0064;
		repeat (3) @(posedge clock);
		`CHK(rot, 1'b0)
		repeat (60) @(posedge clock);
		`CHK(rot, 1'b1)
		wr(`SRCL_OFS_FILT, 32'h0000_0000, `SRCL_RESP_OKAY);
		// Limits kept below overspeed threshold by the configurer
		wr(`SRCL_OFS_FWD_LIM, 32'h0000_0064, `SRCL_RESP_OKAY);
		wr(`SRCL_OFS_REV_LIM, 32'h0000_00c8, `SRCL_RESP_OKAY);
		wr(`SRCL_OFS_MAX_LIM, 32'h0000_0096, `SRCL_RESP_OKAY);
		smode <= 1;
		sref <= 16'h03e8;
		repeat (3) @(posedge clock);
		`CHK(cmd, 16'h0064)
		sref <= 16'hfc18;
		repeat (3) @(posedge clock);
		`CHK(cmd, 16'hff6a)
		mmax <= 16'h0050;
		repeat (3) @(posedge clock);
		`CHK(cmd, 16'hffb0)
		mmax <= 16'h1770;
		sref <= 16'h0005;
		repeat (4) @(posedge clock);
		`CHK(clamp, 1'b0)
		`CHK(cmd, 16'h0005)
		sref <= 16'h0000;
		repeat (3) @(posedge clock);
		p0 = pos;
		hold <= 1;
		repeat (8) @(posedge clock);
		`CHK(clamp, 1'b1)
		sref <= 16'h0005;
		load <= 16'h0005;
		@(posedge clock);
		load <= 16'h0000;
		repeat (30) @(posedge clock);
		`CHK((pos - p0 <= 1) && (p0 - pos <= 1), 1'b1)
		`CHK(cmd, 16'h0000)
		sref <= 16'h000b;
		repeat (3) @(posedge clock);
		`CHK(clamp, 1'b0)
		`CHK(cmd, 16'h000b)
		hold <= 0;
		sref <= 16'h0000;
		// Overspeed fault and its masked, sticky interrupt
		wr(`SRCL_OFS_IRQ_MASK, 32'h0000_0001, `SRCL_RESP_OKAY);
		fb <= 16'h1901;
		repeat (3) @(posedge clock);
		`CHK(ovs, 1'b1)
		`CHK(irq, 1'b1)
		fb <= 16'h1900;
		repeat (3) @(posedge clock);
		`CHK(ovs, 1'b0)
		`CHK(irq, 1'b1)
		wr(`SRCL_OFS_IRQ_STAT, 32'h0000_0007, `SRCL_RESP_OKAY);
		repeat (2) @(posedge clock);
		`CHK(irq, 1'b0)
		// Rotation flag at its threshold, with output routing
		smode <= 0;
		wr(`SRCL_OFS_DO_CFG, 32'h0000_0109, `SRCL_RESP_OKAY);
		fb <= 16'hffec;
		repeat (4) @(posedge clock);
		`CHK(rot, 1'b1)
		`CHK(pins, 4'hf)
		fb <= 16'h0013;
		repeat (4) @(posedge clock);
		`CHK(rot, 1'b0)
		`CHK(pins, 4'he)
		// Speed match window and its run and mode gating
		run <= 1;
		smode <= 1;
		sref <= 16'h0064;
		fb <= 16'h006e;
		repeat (4) @(posedge clock);
		`CHK(match, 1'b1)
		`CHK(pins, 4'hd)
		fb <= 16'h006f;
		repeat (4) @(posedge clock);
		`CHK(match, 1'b0)
		wr(`SRCL_OFS_MATCH_THR, 32'h0000_0014, `SRCL_RESP_OKAY);
		repeat (3) @(posedge clock);
		`CHK(match, 1'b1)
		run <= 0;
		repeat (3) @(posedge clock);
		`CHK(match, 1'b0)
		run <= 1;
		smode <= 0;
		repeat (3) @(posedge clock);
		`CHK(match, 1'b0)
		report_and_stop();
	end
endmodule
